// file: core/smu_mul.sv
// Combinational signed multiply datapath
`timescale 1ns/1ps
module smu_mul (
	input smu_pkg::smu_op_e op,
	input logic round,
	input logic exchange,
	input logic first_top,
	input logic second_top,
	input logic [31:0] operand_first,
	input logic [31:0] operand_second,
	input logic [31:0] accumulate_operand,
	output logic [31:0] result,
	output logic ovf_set
);
	import smu_pkg::*;

	logic signed [63:0] full_prod;
	logic [63:0] msw_sum;
	logic [31:0] msw_word;
	logic [31:0] swapped_second;
	logic signed [31:0] lo_prod;
	logic signed [31:0] hi_prod;
	logic signed [32:0] dual_add;
	logic [31:0] dual_sub;
	logic signed [31:0] half_prod;
	logic signed [47:0] wide_prod;

	// RULE1 full product
	assign full_prod = $signed(operand_first) * $signed(operand_second);
	// RULE2 rounding constant
	assign msw_sum = full_prod + (round ? SMU_ROUND_ADD : 64'h0000_0000_0000_0000);
	assign msw_word = msw_sum[63:32];
	// RULE6 halfword exchange
	assign swapped_second = exchange ? {operand_second[15:0], operand_second[31:16]}
		: operand_second;
	assign lo_prod = $signed(operand_first[15:0]) * $signed(swapped_second[15:0]);
	assign hi_prod = $signed(operand_first[31:16]) * $signed(swapped_second[31:16]);
	assign dual_add = {lo_prod[31], lo_prod} + {hi_prod[31], hi_prod};
	// RULE8 bottom minus top
	assign dual_sub = lo_prod - hi_prod;
	// RULE11 independent halfword picks
	assign half_prod = $signed(smu_pick_half(operand_first, first_top))
		* $signed(smu_pick_half(operand_second, second_top));
	// RULE13 signed halfword multiplier
	assign wide_prod = $signed(operand_first) * $signed(smu_pick_half(operand_second, second_top));

	always_comb
	begin
		result = 32'h0000_0000;
		ovf_set = 1'h0;
		case (op)
			// RULE3 accumulate variant
			SMU_MSW_MULTIPLY_ACCUMULATE: result = accumulate_operand + msw_word;
			// RULE4 subtract variant
			SMU_MSW_MULTIPLY_SUBTRACT: result = accumulate_operand - msw_word;
			// RULE5 plain upper word
			SMU_MSW_MULTIPLY: result = msw_word;
			SMU_DUAL_MULTIPLY_ADD:
			begin
				// RULE7 sum of products
				result = dual_add[31:0];
				// RULE9 overflow of final sum
				ovf_set = dual_add[32] ^ dual_add[31];
			end
			SMU_DUAL_MULTIPLY_SUBTRACT: result = dual_sub;
			// RULE12 full 32-bit product
			SMU_HALFWORD_MULTIPLY: result = half_prod;
			// RULE14 upper 32 of 48 bits
			SMU_WORD_BY_HALFWORD_MULTIPLY: result = wide_prod[47:16];
			default: result = 32'h0000_0000;
		endcase
	end
endmodule // smu_mul

// file: core/smu_pkg.sv
// Constants, types and helpers shared by the signed multiply unit
// Function
// RULE1: Most-significant-word multiplies form the full signed 64-bit product, keep upper word.
// RULE2: Rounding adds 0x80000000 to the product before the upper word is taken.
// RULE3: Accumulate variant adds the third operand to the signed upper word.
// RULE4: Subtract variant subtracts the upper word from the third operand.
// RULE5: Plain variant writes the upper word, rounded or truncated per the option.
// RULE6: Dual multiplies pair bottom/bottom and top/top; exchange swaps second operand halves.
// RULE7: Dual multiply-add writes the sum of both halfword products.
// RULE8: Dual multiply-subtract writes bottom product minus top product.
// RULE9: Dual multiply-add raises the sticky overflow flag when its sum overflows.
// RULE10: No operation changes the negative, zero, carry or overflow condition flags.
// RULE11: Halfword multiply picks bits 15:0 or 31:16 of each operand independently.
// RULE12: Halfword multiply writes the full signed 32-bit product of the halves.
// RULE13: Word-by-halfword multiply picks the second operand half as signed multiplier.
// RULE14: Word-by-halfword multiply writes the upper 32 bits of the 48-bit product.
// RULE15: The instruction source never names stack pointer or program counter registers.
// RULE16: Unit takes op select, modifiers, three operands; returns result and overflow-set.
package smu_pkg;
	localparam int SMU_W = 32;
	localparam int SMU_HW = 16;
	localparam int SMU_AW = 8;
	localparam int SMU_FLAG_W = 4;
	localparam int SMU_EV_W = 2;
	localparam logic [63:0] SMU_ROUND_ADD = 64'h0000_0000_8000_0000;
	localparam logic [7:0] SMU_CTRL_OFS = 8'h00;
	localparam logic [7:0] SMU_STATUS_OFS = 8'h04;
	localparam logic [7:0] SMU_CLEAR_OFS = 8'h08;
	localparam logic [7:0] SMU_ENABLE_OFS = 8'h0C;
	localparam logic [7:0] SMU_RESULT_OFS = 8'h10;
	localparam logic [7:0] SMU_COUNT_OFS = 8'h14;
	localparam int SMU_CTRL_EN_BIT = 0;
	localparam int SMU_EV_OVF_BIT = 0;
	localparam int SMU_EV_DONE_BIT = 1;
	localparam logic SMU_CTRL_EN_RST = 1'h1;
	localparam logic [1:0] SMU_ENABLE_RST = 2'h0;
	localparam logic [1:0] SMU_STATUS_RST = 2'h0;
	localparam logic [31:0] SMU_WORD_RST = 32'h0000_0000;
	localparam int SMU_LATENCY = 1;

	typedef enum logic [2:0] {
		SMU_MSW_MULTIPLY_ACCUMULATE,
		SMU_MSW_MULTIPLY_SUBTRACT,
		SMU_MSW_MULTIPLY,
		SMU_DUAL_MULTIPLY_ADD,
		SMU_DUAL_MULTIPLY_SUBTRACT,
		SMU_HALFWORD_MULTIPLY,
		SMU_WORD_BY_HALFWORD_MULTIPLY
	} smu_op_e;

	// Top or bottom halfword of a word
	function automatic logic [15:0] smu_pick_half(input logic [31:0] word, input logic top);
		smu_pick_half = top ? word[31:16] : word[15:0];
	endfunction
endpackage

// file: core/smu_unit.sv
// Signed multiply unit: request port, register file, interrupt
`timescale 1ns/1ps
module smu_unit (
	input logic core_clk,
	input logic rst_b,
	input logic op_valid,
	input smu_pkg::smu_op_e op_sel,
	input logic op_round,
	input logic op_exchange,
	input logic op_first_top,
	input logic op_second_top,
	input logic [smu_pkg::SMU_W-1:0] operand_first,
	input logic [smu_pkg::SMU_W-1:0] operand_second,
	input logic [smu_pkg::SMU_W-1:0] accumulate_operand,
	input logic [smu_pkg::SMU_FLAG_W-1:0] flags_in,
	input logic [smu_pkg::SMU_AW-1:0] reg_addr,
	input logic [smu_pkg::SMU_W-1:0] reg_wdata,
	input logic reg_wr,
	input logic reg_rd,
	output logic [smu_pkg::SMU_W-1:0] reg_rdata,
	output logic result_valid,
	output logic [smu_pkg::SMU_W-1:0] result,
	output logic q_set,
	output logic [smu_pkg::SMU_FLAG_W-1:0] flags_out,
	output logic irq
);
	import smu_pkg::*;

	logic unit_enable;
	logic [SMU_EV_W-1:0] status;
	logic [SMU_EV_W-1:0] enable;
	logic [SMU_W-1:0] last_result;
	logic [SMU_W-1:0] op_count;

	logic [SMU_W-1:0] dp_result;
	logic dp_ovf;

	// Datapath
	smu_mul u_mul (
		.op(op_sel),
		.round(op_round),
		.exchange(op_exchange),
		.first_top(op_first_top),
		.second_top(op_second_top),
		.operand_first(operand_first),
		.operand_second(operand_second),
		.accumulate_operand(accumulate_operand),
		.result(dp_result),
		.ovf_set(dp_ovf)
	);

	// Request acceptance and register decode
	wire take_op = op_valid & unit_enable;
	wire wr_ctrl = reg_wr && reg_addr == SMU_CTRL_OFS;
	wire wr_clear = reg_wr && reg_addr == SMU_CLEAR_OFS;
	wire wr_enable = reg_wr && reg_addr == SMU_ENABLE_OFS;
	wire [SMU_EV_W-1:0] events;
	wire [SMU_EV_W-1:0] clear_mask;
	wire [SMU_EV_W-1:0] next_status;
	wire [SMU_EV_W-1:0] next_enable;
	wire next_unit_enable;
	wire [SMU_W-1:0] read_word;

	assign events[SMU_EV_OVF_BIT] = take_op & dp_ovf;
	assign events[SMU_EV_DONE_BIT] = take_op;
	assign clear_mask = wr_clear ? reg_wdata[SMU_EV_W-1:0] : SMU_STATUS_RST;
	// Set wins over clear
	assign next_status = (status & ~clear_mask) | events;
	assign next_enable = wr_enable ? reg_wdata[SMU_EV_W-1:0] : enable;
	assign next_unit_enable = wr_ctrl ? reg_wdata[SMU_CTRL_EN_BIT] : unit_enable;

	assign read_word =
		reg_addr == SMU_CTRL_OFS ? {31'h0000_0000, unit_enable} :
		reg_addr == SMU_STATUS_OFS ? {30'h0000_0000, status} :
		reg_addr == SMU_ENABLE_OFS ? {30'h0000_0000, enable} :
		reg_addr == SMU_RESULT_OFS ? last_result :
		reg_addr == SMU_COUNT_OFS ? op_count : SMU_WORD_RST;

	// Control and interrupt registers
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			unit_enable <= SMU_CTRL_EN_RST;
			status <= SMU_STATUS_RST;
			enable <= SMU_ENABLE_RST;
			irq <= 1'h0;
		end
		else
		begin
			unit_enable <= next_unit_enable;
			status <= next_status;
			enable <= next_enable;
			irq <= |(next_status & next_enable);
		end
	end

	// Read data for one cycle only
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			reg_rdata <= SMU_WORD_RST;
		else
			reg_rdata <= reg_rd ? read_word : SMU_WORD_RST;
	end

	// Result stage
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			result_valid <= 1'h0;
			q_set <= 1'h0;
			result <= SMU_WORD_RST;
			last_result <= SMU_WORD_RST;
			op_count <= SMU_WORD_RST;
			flags_out <= 4'h0;
		end
		else
		begin
			// RULE16 one result per accepted request
			result_valid <= take_op;
			// RULE9 sticky flag set indication
			q_set <= take_op & dp_ovf;
			if (take_op)
			begin
				result <= dp_result;
				last_result <= dp_result;
				op_count <= op_count + 32'h0000_0001;
				// RULE10 condition flags pass unchanged
				flags_out <= flags_in;
			end
		end
	end

	// Reference values read only by the checks below
	logic signed [63:0] chk_full;
	logic [63:0] chk_rnd_full;
	logic [31:0] chk_trunc;
	logic [31:0] chk_round;
	logic [31:0] chk_acc;
	logic [31:0] chk_sub;
	logic signed [31:0] chk_bb;
	logic signed [31:0] chk_tt;
	logic signed [31:0] chk_bt;
	logic signed [31:0] chk_tb;
	logic signed [32:0] chk_dual;
	logic chk_dual_ovf;
	logic [31:0] chk_dual_sum;
	logic [31:0] chk_xsub;
	logic signed [31:0] chk_half;
	logic signed [47:0] chk_wide;
	logic [31:0] chk_whalf;

	assign chk_full = $signed(operand_first) * $signed(operand_second);
	assign chk_rnd_full = chk_full + SMU_ROUND_ADD;
	assign chk_trunc = chk_full[63:32];
	assign chk_round = chk_rnd_full[63:32];
	assign chk_acc = accumulate_operand + chk_trunc;
	assign chk_sub = accumulate_operand - chk_round;
	assign chk_bb = $signed(operand_first[15:0]) * $signed(operand_second[15:0]);
	assign chk_tt = $signed(operand_first[31:16]) * $signed(operand_second[31:16]);
	assign chk_bt = $signed(operand_first[15:0]) * $signed(operand_second[31:16]);
	assign chk_tb = $signed(operand_first[31:16]) * $signed(operand_second[15:0]);
	assign chk_dual = {chk_bb[31], chk_bb} + {chk_tt[31], chk_tt};
	assign chk_dual_sum = chk_dual[31:0];
	assign chk_dual_ovf = chk_dual[32] != chk_dual[31];
	assign chk_xsub = chk_bt - chk_tb;
	assign chk_half = $signed(op_first_top ? operand_first[31:16] : operand_first[15:0])
		* $signed(op_second_top ? operand_second[31:16] : operand_second[15:0]);
	assign chk_wide = $signed(operand_first)
		* $signed(op_second_top ? operand_second[31:16] : operand_second[15:0]);
	assign chk_whalf = chk_wide[47:16];

	default clocking dflt_cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);

	// RULE1 truncated upper word
	msw_trunc_a: assert property ( // RULE5
		take_op && op_sel == SMU_MSW_MULTIPLY && !op_round
		|=> result_valid && result == $past(chk_trunc))
		else $error("Plain upper-word multiply result wrong");

	// RULE2 rounded upper word
	msw_round_a: assert property ( // RULE2
		take_op && op_sel == SMU_MSW_MULTIPLY && op_round
		|=> result == $past(chk_round))
		else $error("Rounded upper-word multiply result wrong");

	// RULE3 accumulate variant
	msw_acc_a: assert property ( // RULE3
		take_op && op_sel == SMU_MSW_MULTIPLY_ACCUMULATE && !op_round
		|=> result == $past(chk_acc))
		else $error("Upper-word accumulate result wrong");

	// RULE4 subtract variant
	msw_sub_a: assert property ( // RULE4
		take_op && op_sel == SMU_MSW_MULTIPLY_SUBTRACT && op_round
		|=> result == $past(chk_sub))
		else $error("Upper-word subtract result wrong");

	// RULE7 dual add straight pairing
	dual_add_a: assert property ( // RULE7
		take_op && op_sel == SMU_DUAL_MULTIPLY_ADD && !op_exchange
		|=> result == $past(chk_dual_sum))
		else $error("Dual multiply-add result wrong");

	// RULE6 exchanged dual subtract
	dual_xsub_a: assert property ( // RULE8
		take_op && op_sel == SMU_DUAL_MULTIPLY_SUBTRACT && op_exchange
		|=> result == $past(chk_xsub))
		else $error("Exchanged dual multiply-subtract result wrong");

	// RULE9 overflow indication and sticky bit
	q_flag_a: assert property ( // RULE9
		take_op && op_sel == SMU_DUAL_MULTIPLY_ADD && !op_exchange
		|=> q_set == $past(chk_dual_ovf) && (!q_set || status[SMU_EV_OVF_BIT]))
		else $error("Overflow set indication wrong");

	// RULE9 only dual add raises it
	q_source_a: assert property ( // RULE9
		q_set |-> $past(op_sel) == SMU_DUAL_MULTIPLY_ADD && $past(take_op))
		else $error("Overflow raised by wrong operation");

	// RULE12 halfword product
	half_mul_a: assert property ( // RULE11
		take_op && op_sel == SMU_HALFWORD_MULTIPLY
		|=> result == $past(chk_half))
		else $error("Halfword multiply result wrong");

	// RULE14 word by halfword upper bits
	word_half_a: assert property ( // RULE13
		take_op && op_sel == SMU_WORD_BY_HALFWORD_MULTIPLY
		|=> result == $past(chk_whalf))
		else $error("Word-by-halfword multiply result wrong");

	// RULE10 flags untouched
	flags_keep_a: assert property ( // RULE10
		take_op |=> flags_out == $past(flags_in) ##1 ($past(take_op) || $stable(flags_out)))
		else $error("Condition flags altered");

	// RULE16 one result per request
	result_pulse_a: assert property ( // RULE16
		result_valid == $past(take_op) && (!$past(op_valid) || $past(unit_enable)
		|| !result_valid))
		else $error("Result valid not tied to accepted request");

	// Interrupt follows enabled status
	irq_level_a: assert property (
		irq == |(status & enable))
		else $error("Interrupt level disagrees with status and enable");
endmodule // smu_unit

// file: dv/smu_core_model.sv
// Core-side model: decode stage driving multiply requests
`timescale 1ns/1ps
module smu_core_model (
	input logic core_clk,
	input logic rst_b,
	input logic t_go,
	input smu_pkg::smu_op_e t_sel,
	input logic [3:0] t_mod,
	input logic [31:0] t_a,
	input logic [31:0] t_b,
	input logic [31:0] t_c,
	input logic [3:0] t_fl,
	output logic op_valid,
	output smu_pkg::smu_op_e op_sel,
	output logic op_round,
	output logic op_exchange,
	output logic op_first_top,
	output logic op_second_top,
	output logic [31:0] operand_first,
	output logic [31:0] operand_second,
	output logic [31:0] accumulate_operand,
	output logic [3:0] flags_in
);
	import smu_pkg::*;
	// general registers only
	// Operands come from the general file, never stack pointer or program counter
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			op_valid <= 1'b0;
			op_sel <= SMU_MSW_MULTIPLY;
			{op_round, op_exchange, op_first_top, op_second_top} <= 4'h0;
			operand_first <= 32'h0;
			operand_second <= 32'h0;
			accumulate_operand <= 32'h0;
			flags_in <= 4'h0;
		end
		else
		begin
			op_valid <= t_go;
			op_sel <= t_sel;
			{op_round, op_exchange, op_first_top, op_second_top} <= t_mod;
			flags_in <= t_fl;
			// Released operand lines toggle rather than hold
			operand_first <= t_go ? t_a : ~operand_first;
			operand_second <= t_go ? t_b : ~operand_second;
			accumulate_operand <= t_go ? t_c : ~accumulate_operand;
		end
	end
endmodule // smu_core_model

// file: dv/tb.sv
// Self-checking bench for the signed multiply unit
`timescale 1ns/1ps
module tb;
	import smu_pkg::*;
	typedef struct {smu_op_e op; logic [3:0] md; logic [31:0] a, b, c, r; logic q;} smu_row_s;
	smu_row_s rows[$];
	logic core_clk, rst_b = 1'b0, t_go = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, seen;
	smu_op_e t_sel = SMU_MSW_MULTIPLY, op_sel;
	logic [3:0] t_mod = 4'h0, t_fl = 4'h0, flags_in, flags_out;
	logic [31:0] t_a = 32'h0, t_b = 32'h0, t_c = 32'h0, reg_wdata = 32'h0;
	logic [7:0] reg_addr = 8'h0;
	logic op_valid, op_round, op_exchange, op_first_top, op_second_top;
	logic [31:0] operand_first, operand_second, accumulate_operand, reg_rdata, result;
	logic result_valid, q_set, irq;
	int error_cnt = 0, samples_checked = 0, n;

	smu_core_model smu_core_model_i (.core_clk(core_clk), .rst_b(rst_b), .t_go(t_go),
		.t_sel(t_sel), .t_mod(t_mod), .t_a(t_a), .t_b(t_b), .t_c(t_c), .t_fl(t_fl),
		.op_valid(op_valid), .op_sel(op_sel), .op_round(op_round), .op_exchange(op_exchange),
		.op_first_top(op_first_top), .op_second_top(op_second_top),
		.operand_first(operand_first), .operand_second(operand_second),
		.accumulate_operand(accumulate_operand), .flags_in(flags_in));
	smu_unit smu_unit_i (.core_clk(core_clk), .rst_b(rst_b), .op_valid(op_valid),
		.op_sel(op_sel), .op_round(op_round), .op_exchange(op_exchange),
		.op_first_top(op_first_top), .op_second_top(op_second_top),
		.operand_first(operand_first), .operand_second(operand_second),
		.accumulate_operand(accumulate_operand), .flags_in(flags_in), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.result_valid(result_valid), .result(result), .q_set(q_set),
		.flags_out(flags_out), .irq(irq));

	initial
	begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	task automatic give_verdict();
		$display("Checks %0d, errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e)
		begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic add(smu_op_e op, logic [3:0] md, logic [31:0] a, b, c, r, logic q);
		rows.push_back('{op, md, a, b, c, r, q});
	endtask

	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= ad;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [7:0] ad, input logic [31:0] e, input string nm);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= ad;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		chk(nm, e, reg_rdata);
	endtask

	task automatic drive(input int i, input logic go);
		@(posedge core_clk);
		t_go <= go;
		t_sel <= rows[i].op;
		t_mod <= rows[i].md;
		t_a <= rows[i].a;
		t_b <= rows[i].b;
		t_c <= rows[i].c;
		t_fl <= 4'(i);
	endtask

	task automatic chk_row(input int i);
		chk($sformatf("result row %0d", i), rows[i].r, result);
		chk("q_set", {31'h0, rows[i].q}, {31'h0, q_set});
		chk("flags_out", {28'h0, 4'(i)}, {28'h0, flags_out});
	endtask

	initial
	begin
		add(SMU_MSW_MULTIPLY, 4'h0, 32'h40000000, 32'h4, 32'h0, 32'h1, 0);
		add(SMU_MSW_MULTIPLY, 4'h0, 32'h10000, 32'h8000, 32'h0, 32'h0, 0);
		add(SMU_MSW_MULTIPLY, 4'h8, 32'h10000, 32'h8000, 32'h0, 32'h1, 0);
		add(SMU_MSW_MULTIPLY, 4'h0, 32'hFFFFFFFF, 32'h2, 32'h0, 32'hFFFFFFFF, 0);
		add(SMU_MSW_MULTIPLY_ACCUMULATE, 4'h0, 32'h40000000, 32'h4, 32'h10, 32'h11, 0);
		add(SMU_MSW_MULTIPLY_ACCUMULATE, 4'h8, 32'h10000, 32'h8000, 32'h10, 32'h11, 0);
		add(SMU_MSW_MULTIPLY_SUBTRACT, 4'h0, 32'h40000000, 32'h4, 32'h10, 32'hF, 0);
		add(SMU_MSW_MULTIPLY_SUBTRACT, 4'h8, 32'h10000, 32'h8000, 32'h0, 32'hFFFFFFFF, 0);
		add(SMU_DUAL_MULTIPLY_ADD, 4'h0, 32'h30002, 32'h50004, 32'h0, 32'h17, 0);
		add(SMU_DUAL_MULTIPLY_ADD, 4'h4, 32'h30002, 32'h50004, 32'h0, 32'h16, 0);
		add(SMU_DUAL_MULTIPLY_ADD, 4'h0, 32'h80008000, 32'h80008000, 0, 32'h80000000, 1);
		add(SMU_DUAL_MULTIPLY_SUBTRACT, 4'h0, 32'h30002, 32'h50004, 0, 32'hFFFFFFF9, 0);
		add(SMU_DUAL_MULTIPLY_SUBTRACT, 4'h4, 32'h30002, 32'h50004, 0, 32'hFFFFFFFE, 0);
		add(SMU_DUAL_MULTIPLY_SUBTRACT, 4'h0, 32'h80008000, 32'h80008000, 0, 32'h0, 0);
		add(SMU_HALFWORD_MULTIPLY, 4'h0, 32'h3FFFE, 32'h50004, 0, 32'hFFFFFFF8, 0);
		add(SMU_HALFWORD_MULTIPLY, 4'h2, 32'h3FFFE, 32'h50004, 0, 32'hC, 0);
		add(SMU_HALFWORD_MULTIPLY, 4'h1, 32'h3FFFE, 32'h50004, 0, 32'hFFFFFFF6, 0);
		add(SMU_HALFWORD_MULTIPLY, 4'h3, 32'h3FFFE, 32'h50004, 0, 32'hF, 0);
		add(SMU_WORD_BY_HALFWORD_MULTIPLY, 4'h0, 32'h10000, 32'h20004, 0, 32'h4, 0);
		add(SMU_WORD_BY_HALFWORD_MULTIPLY, 4'h1, 32'h10000, 32'h20004, 0, 32'h2, 0);
		add(SMU_WORD_BY_HALFWORD_MULTIPLY, 4'h0, 32'hFFFF0000, 32'h3, 0, 32'hFFFFFFFD, 0);
		repeat (16) @(posedge core_clk);
		rst_b <= 1'b1;
		rd(SMU_CTRL_OFS, 32'h1, "ctrl");
		rd(SMU_STATUS_OFS, 32'h0, "status");
		rd(SMU_ENABLE_OFS, 32'h0, "enable");
		rd(SMU_COUNT_OFS, 32'h0, "count");
		rd(8'h20, 32'h0, "unmapped");
		chk("irq", 32'h0, {31'h0, irq});
		$display("reset test done");
		for (n = 0; n < rows.size(); n++)
		begin
			drive(n, 1'b1);
			drive(n, 1'b0);
			#1;
			for (int k = 0; k < 8 && result_valid !== 1'b1; k++)
				@(posedge core_clk) #1;
			chk("result_valid", 32'h1, {31'h0, result_valid});
			if (result_valid !== 1'b1)
				give_verdict();
			chk_row(n);
		end
		$display("table test done");
		// Back-to-back requests, no gap
		drive(8, 1'b1);
		drive(10, 1'b1);
		drive(10, 1'b0);
		#1;
		chk("b2b first", 32'h17, result);
		@(posedge core_clk) #1;
		chk("b2b valid", 32'h1, {31'h0, result_valid});
		chk("b2b q_set", 32'h1, {31'h0, q_set});
		rd(SMU_COUNT_OFS, rows.size() + 2, "count");
		rd(SMU_STATUS_OFS, 32'h3, "status");
		chk("irq masked", 32'h0, {31'h0, irq});
		wr(SMU_ENABLE_OFS, 32'h1);
		chk("irq on", 32'h1, {31'h0, irq});
		wr(SMU_CLEAR_OFS, 32'h1);
		chk("irq cleared", 32'h0, {31'h0, irq});
		rd(SMU_STATUS_OFS, 32'h2, "status");
		wr(SMU_ENABLE_OFS, 32'h3);
		chk("irq done", 32'h1, {31'h0, irq});
		wr(SMU_CLEAR_OFS, 32'h3);
		chk("irq off", 32'h0, {31'h0, irq});
		wr(SMU_RESULT_OFS, 32'hFFFFFFFF);
		wr(8'h20, 32'hFFFFFFFF);
		rd(SMU_RESULT_OFS, 32'h80000000, "result reg");
		rd(8'h20, 32'h0, "unmapped");
		$display("register test done");
		wr(SMU_CTRL_OFS, 32'h0);
		drive(0, 1'b1);
		drive(0, 1'b0);
		seen = 1'b0;
		repeat (4) @(posedge core_clk) #1 seen = seen | result_valid;
		chk("refused valid", 32'h0, {31'h0, seen});
		rd(SMU_COUNT_OFS, rows.size() + 2, "count refused");
		rd(SMU_STATUS_OFS, 32'h0, "status refused");
		wr(SMU_CTRL_OFS, 32'h1);
		$display("refusal test done");
		@(posedge core_clk);
		rst_b <= 1'b0;
		#1;
		chk("reset result", 32'h0, result);
		repeat (2) @(posedge core_clk);
		rst_b <= 1'b1;
		rd(SMU_COUNT_OFS, 32'h0, "count after reset");
		$display("mid-run reset test done");
		give_verdict();
	end
endmodule // tb
